// ===== hdl/ssa_params.svh
// constants for the two-wire slave address receiver
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH

// =============================================================
// widths
`define SSA_BYTE_W 8
`define SSA_CNT_W 4

// =============================================================
// protocol figures
`define SSA_LAST_BIT 4'h8
`define SSA_FIRST_BIT 4'h1
`define SSA_TEN_PREFIX 5'h1e

// =============================================================
// reset values
`define SSA_OWN_ADDR_RST 8'h00

`endif

// ===== hdl/ssa_pkg.sv
// types shared by the two-wire slave address receiver
`include "ssa_params.svh"

package ssa_pkg;

  // =============================================================
  // link side address tracking, gray along idle -> high -> addressed
  typedef enum logic [1:0] {
    SSA_LS_IDLE = 2'b00,
    SSA_LS_HIGH = 2'b01,
    SSA_LS_ADDRD = 2'b11
  } ssa_lstate_t;

  // =============================================================
  // one finished byte as reported by the link side
  typedef struct packed {
    logic xfer;
    logic is_addr;
    logic ten_addr;
    logic rw;
  } ssa_evt_t;

  // quasi-static settings handed to the link side
  typedef struct packed {
    logic [`SSA_BYTE_W-1:0] own;
    logic ten;
    logic bf;
    logic ov;
  } ssa_cfg_t;

  // =============================================================
  // core clock state
  typedef struct packed {
    logic [1:0] ev_sync;
    logic ev_prev;
    ssa_cfg_t cfg;
    logic addr_update;
    logic irq_flag;
    logic rw;
    logic link_hold;
  } ssa_core_t;

  // two-entry buffer state
  typedef struct packed {
    logic [`SSA_BYTE_W-1:0] head;
    logic [`SSA_BYTE_W-1:0] tail;
    logic head_v;
    logic tail_v;
  } ssa_buf_t;

endpackage : ssa_pkg

// ===== hdl/ssa_buf.sv
// two-entry receive buffer with registered output
`timescale 1ns/100ps
`include "ssa_params.svh"

module ssa_buf (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [`SSA_BYTE_W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [`SSA_BYTE_W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  // =============================================================
  // state
  ssa_pkg::ssa_buf_t st;
  ssa_pkg::ssa_buf_t next_st;

  always_comb begin
    next_st = st;
    if (st.head_v && out_ready_in) begin
      next_st.head = st.tail;
      next_st.head_v = st.tail_v;
      next_st.tail_v = 1'b0;
    end
    // ready looks at the old tail only, so a full buffer never overwrites
    if (in_valid_in && !st.tail_v) begin
      if (!next_st.head_v) begin
        next_st.head = in_data_in;
        next_st.head_v = 1'b1;
      end else begin
        next_st.tail = in_data_in;
        next_st.tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready_out = ~st.tail_v;
  assign out_data_out = st.head;
  assign out_valid_out = st.head_v;

endmodule : ssa_buf

// ===== hdl/ssa_top.sv
// two-wire slave: start detect, address receive, ack and flag logic
`timescale 1ns/100ps
`include "ssa_params.svh"

// Function
// - when enabled, wait for START, then shift eight bits in.
// - sample each incoming data bit on the rising edge of SCL.
// - compare shift register bits seven to one with own address.
// - address comparison happens on the falling edge of SCL pulse eight.
// - on match with buffer free and no overflow: buffer byte, flag full, ACK.
// - interrupt flag set on falling edge of ninth SCL, output gated by enable.
// - ten-bit address recognised by 11110 prefix then A9, A8 and direction.
// - after a ten-bit high byte with direction clear and after the matching low byte set update flag, hold SCL low.
// - buffer read clears full flag; software clears interrupt flag each byte.
// - after repeated START, high address byte accepted again, flags set.
// - full or overflow: no buffer load, no ACK, interrupt flag still set.
// - interrupt flag raised once per matching address byte and per data byte after it; other bytes leave it clear.
// - matched address with direction clear clears status bit, buffers address.
module ssa_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic enable_in,
  input wire logic ten_bit_mode_in,
  input wire logic [`SSA_BYTE_W-1:0] own_addr_in,
  input wire logic own_addr_wr_in,
  input wire logic rx_ready_in,
  input wire logic irq_clear_in,
  input wire logic ovf_clear_in,
  input wire logic irq_enable_in,
  output logic [`SSA_BYTE_W-1:0] rx_data_out,
  output logic rx_valid_out,
  output logic buffer_full_out,
  output logic overflow_out,
  output logic irq_flag_out,
  output logic irq_out,
  output logic addr_update_out,
  output logic read_write_out
);

  // =============================================================
  // declarations
  localparam ssa_pkg::ssa_core_t CORE_RST = '{
    ev_sync: 2'h0,
    ev_prev: 1'b0,
    cfg: '{own: `SSA_OWN_ADDR_RST, ten: 1'b0, bf: 1'b0, ov: 1'b0},
    addr_update: 1'b0,
    irq_flag: 1'b0,
    rw: 1'b0,
    link_hold: 1'b1
  };

  ssa_pkg::ssa_core_t st;
  ssa_pkg::ssa_core_t next_st;

  // link side, clocked by scl_in; start_flag is clocked by falling sda_in
  logic start_flag;
  logic start_taken;
  logic start_clr;
  logic fresh;
  logic [`SSA_CNT_W-1:0] bit_cnt;
  logic [`SSA_BYTE_W-1:0] rx_shift_reg;
  ssa_pkg::ssa_cfg_t cfg_s1;
  ssa_pkg::ssa_cfg_t cfg_s2;
  ssa_pkg::ssa_lstate_t lstate;
  ssa_pkg::ssa_lstate_t next_lstate;
  ssa_pkg::ssa_evt_t link_evt;
  ssa_pkg::ssa_evt_t next_evt;
  logic [`SSA_BYTE_W-1:0] link_byte;
  logic ack_slot;
  logic sda_drv;
  logic ev_tog;
  logic hit;
  logic match_hi;
  logic ten_hdr;

  // own address and mode crossing into the scl domain
  logic [`SSA_BYTE_W-1:0] own_hold;
  logic ten_hold;
  logic offer_tog;
  logic offer_idle;
  logic [1:0] taken_sync;
  logic [1:0] offer_sync;
  logic taken_tog;
  logic [`SSA_BYTE_W-1:0] own_link;
  logic ten_link;

  // buffer wiring
  logic buf_push;
  logic buf_in_ready;
  logic buffer_full_flag;
  logic ev_pulse;

  // =============================================================
  // start marker
  // sda falling while scl is high is a START; the flag is held through any
  // data change before the first rising edge and cleared by that edge.
  // link_hold is a core flop, so the clear is glitch free.
  assign start_clr = st.link_hold | start_taken;

  always_ff @(negedge sda_in or posedge start_clr) begin
    if (start_clr) begin
      start_flag <= 1'b0;
    end else begin
      start_flag <= start_flag | scl_in;
    end
  end

  // =============================================================
  // bit shifting on rising scl
  always_ff @(posedge scl_in or posedge st.link_hold) begin
    if (st.link_hold) begin
      start_taken <= 1'b0;
      fresh <= 1'b0;
      bit_cnt <= '0;
      rx_shift_reg <= '0;
    end else begin
      start_taken <= start_flag;
      if (start_flag) begin
        rx_shift_reg <= {{(`SSA_BYTE_W-1){1'b0}}, sda_in};
        bit_cnt <= `SSA_FIRST_BIT;
        fresh <= 1'b1;
      end else if (bit_cnt == `SSA_LAST_BIT) begin
        // acknowledge clock: nothing shifts
        bit_cnt <= '0;
      end else begin
        rx_shift_reg <= {rx_shift_reg[`SSA_BYTE_W-2:0], sda_in};
        bit_cnt <= bit_cnt + `SSA_FIRST_BIT;
        if (bit_cnt == '0) begin
          fresh <= 1'b0;
        end
      end
    end
  end

  // =============================================================
  // address decision, evaluated for the falling edge of pulse eight
  assign match_hi = (rx_shift_reg[`SSA_BYTE_W-1:1] == own_link[`SSA_BYTE_W-1:1]);
  assign ten_hdr = (rx_shift_reg[`SSA_BYTE_W-1:3] == `SSA_TEN_PREFIX);

  always_comb begin
    hit = 1'b0;
    next_lstate = lstate;
    next_evt = '0;
    next_evt.rw = rx_shift_reg[0];
    if (fresh) begin
      next_evt.is_addr = 1'b1;
      if (ten_link) begin
        if (match_hi && ten_hdr && !rx_shift_reg[0]) begin
          // first byte is a write, so the low byte follows
          hit = 1'b1;
          next_evt.ten_addr = 1'b1;
          next_lstate = ssa_pkg::SSA_LS_HIGH;
        end else if (match_hi && ten_hdr && lstate == ssa_pkg::SSA_LS_ADDRD) begin
          // read after repeated START: high byte alone re-selects us
          hit = 1'b1;
        end else begin
          next_lstate = ssa_pkg::SSA_LS_IDLE;
        end
      end else if (match_hi) begin
        hit = 1'b1;
        next_lstate = ssa_pkg::SSA_LS_ADDRD;
      end else begin
        next_lstate = ssa_pkg::SSA_LS_IDLE;
      end
    end else if (lstate == ssa_pkg::SSA_LS_HIGH) begin
      next_evt.is_addr = 1'b1;
      // the low byte has no direction bit; the high byte was a write
      next_evt.rw = 1'b0;
      if (rx_shift_reg == own_link) begin
        hit = 1'b1;
        next_evt.ten_addr = 1'b1;
        next_lstate = ssa_pkg::SSA_LS_ADDRD;
      end else begin
        next_lstate = ssa_pkg::SSA_LS_IDLE;
      end
    end else if (lstate == ssa_pkg::SSA_LS_ADDRD) begin
      hit = 1'b1;
    end
    // a full buffer or a standing overflow refuses the byte
    next_evt.xfer = hit & ~cfg_s2.bf & ~cfg_s2.ov;
  end

  // =============================================================
  // falling scl: settings sync, decision, ack drive, event toggle
  // full and overflow are single bits and sync on their own; own address and
  // mode form a word, so they are copied only once an offer toggle has settled
  always_ff @(negedge scl_in or posedge st.link_hold) begin
    if (st.link_hold) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      offer_sync <= 2'h0;
      taken_tog <= 1'b0;
      own_link <= `SSA_OWN_ADDR_RST;
      ten_link <= 1'b0;
      lstate <= ssa_pkg::SSA_LS_IDLE;
      link_evt <= '0;
      link_byte <= '0;
      ack_slot <= 1'b0;
      sda_drv <= 1'b0;
      ev_tog <= 1'b0;
    end else begin
      cfg_s1 <= st.cfg;
      cfg_s2 <= cfg_s1;
      // the echo tells the core that own_hold may move again
      offer_sync <= {offer_sync[0], offer_tog};
      if (offer_sync[1] != taken_tog) begin
        own_link <= own_hold;
        ten_link <= ten_hold;
        taken_tog <= offer_sync[1];
      end
      if (ack_slot) begin
        // falling edge of the ninth pulse ends the ack and reports the byte
        sda_drv <= 1'b0;
        ack_slot <= 1'b0;
        ev_tog <= ~ev_tog;
      end else if (bit_cnt == `SSA_LAST_BIT) begin
        lstate <= next_lstate;
        if (hit) begin
          link_evt <= next_evt;
          link_byte <= rx_shift_reg;
          ack_slot <= 1'b1;
          sda_drv <= next_evt.xfer;
        end
      end
    end
  end

  // =============================================================
  // core clock: event crossing and software flags
  assign ev_pulse = st.ev_sync[1] ^ st.ev_prev;
  assign buffer_full_flag = rx_valid_out;

  always_comb begin
    next_st = st;
    buf_push = 1'b0;
    next_st.ev_sync = {st.ev_sync[0], ev_tog};
    next_st.ev_prev = st.ev_sync[1];
    next_st.link_hold = ~enable_in;
    if (st.link_hold) begin
      // the link toggle restarts at zero; follow it so no false event appears
      next_st.ev_sync = 2'h0;
      next_st.ev_prev = 1'b0;
    end
    next_st.cfg.ten = ten_bit_mode_in;
    next_st.cfg.bf = buffer_full_flag | ~buf_in_ready;
    // clears first, so an event in the same cycle wins
    if (own_addr_wr_in) begin
      next_st.cfg.own = own_addr_in;
      next_st.addr_update = 1'b0;
    end
    if (irq_clear_in) begin
      next_st.irq_flag = 1'b0;
    end
    if (ovf_clear_in) begin
      next_st.cfg.ov = 1'b0;
    end
    if (ev_pulse) begin
      next_st.irq_flag = 1'b1;
      if (link_evt.ten_addr) begin
        next_st.addr_update = 1'b1;
      end
      if (link_evt.xfer) begin
        buf_push = 1'b1;
        if (link_evt.is_addr) begin
          next_st.rw = link_evt.rw;
        end
      end else begin
        next_st.cfg.ov = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  // =============================================================
  // own address offer towards the link side
  // a new word goes out only after the last one was echoed, so own_hold never
  // moves while the link may copy it; costs a few scl edges of latency
  assign offer_idle = (taken_sync[1] == offer_tog);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || st.link_hold) begin
      own_hold <= `SSA_OWN_ADDR_RST;
      ten_hold <= 1'b0;
      offer_tog <= 1'b0;
      taken_sync <= 2'h0;
    end else begin
      taken_sync <= {taken_sync[0], taken_tog};
      if (offer_idle && (own_hold != st.cfg.own || ten_hold != st.cfg.ten)) begin
        own_hold <= st.cfg.own;
        ten_hold <= st.cfg.ten;
        offer_tog <= ~offer_tog;
      end
    end
  end

  // =============================================================
  // receive buffer; a stalled reader shows as full to the link side
  ssa_buf u_buf (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_data_in(link_byte),
    .in_valid_in(buf_push),
    .in_ready_out(buf_in_ready),
    .out_data_out(rx_data_out),
    .out_valid_out(rx_valid_out),
    .out_ready_in(rx_ready_in)
  );

  // =============================================================
  // outputs
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = st.addr_update;
  assign sda_oe_out = sda_drv;
  assign buffer_full_out = buffer_full_flag;
  assign overflow_out = st.cfg.ov;
  assign irq_flag_out = st.irq_flag;
  assign irq_out = st.irq_flag & irq_enable_in;
  assign addr_update_out = st.addr_update;
  assign read_write_out = st.rw;

endmodule : ssa_top

// ===== dv/ssa_asserts.sv
// concurrent checks on the two-wire slave ports
`timescale 1ns/100ps
module ssa_asserts (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ten_bit_mode_in,
  input wire logic own_addr_wr_in,
  input wire logic irq_clear_in,
  input wire logic ovf_clear_in,
  input wire logic irq_enable_in,
  input wire logic sda_oe_out,
  input wire logic scl_oe_out,
  input wire logic rx_valid_out,
  input wire logic buffer_full_out,
  input wire logic overflow_out,
  input wire logic irq_flag_out,
  input wire logic irq_out,
  input wire logic addr_update_out
);
  // =============================================================
  // one core clock domain; ack end is seen a cycle or two late
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_ack_end;
    $fell(sda_oe_out);
  endsequence
  property p_irq_gate; irq_out == (irq_flag_out && irq_enable_in); endproperty
  property p_bf; buffer_full_out == rx_valid_out; endproperty
  property p_irq_after; s_ack_end |-> ##[1:6] irq_flag_out; endproperty
  property p_push; s_ack_end ##0 !rx_valid_out |-> ##[1:8] rx_valid_out; endproperty
  property p_irq_keep; irq_flag_out && !irq_clear_in |=> irq_flag_out; endproperty
  property p_ua_wr; own_addr_wr_in |=> !addr_update_out && !scl_oe_out; endproperty
  property p_ua_scl; $rose(addr_update_out) |-> ##[0:3] scl_oe_out; endproperty
  property p_ua_7; !ten_bit_mode_in |-> !addr_update_out; endproperty
  property p_ovf_keep; overflow_out && !ovf_clear_in |=> overflow_out; endproperty
  property p_ovf_irq; $rose(overflow_out) |-> ##[0:2] irq_flag_out; endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq gate");
  a_bf: assert property (p_bf) else $error("full flag");
  a_irq_after: assert property (p_irq_after) else $error("irq late");
  a_push: assert property (p_push) else $error("no push");
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
  a_ua_wr: assert property (p_ua_wr) else $error("ua clear");
  a_ua_scl: assert property (p_ua_scl) else $error("no stretch");
  a_ua_7: assert property (p_ua_7) else $error("ua in 7 bit");
  a_ovf_keep: assert property (p_ovf_keep) else $error("ovf lost");
  a_ovf_irq: assert property (p_ovf_irq) else $error("ovf no irq");
endmodule : ssa_asserts

// ===== dv/ssa_master.sv
// two-wire bus master model, 48 ns bit clock
`timescale 1ns/100ps
module ssa_master (
  output logic scl_drv_out,
  output logic sda_drv_out,
  input wire logic scl_in,
  input wire logic sda_in
);
  // 1 releases a line; clock stands high between frames
  logic hung = 1'b0;
  initial begin
    scl_drv_out = 1'b1;
    sda_drv_out = 1'b1;
  end
  task automatic start();
    sda_drv_out = 1'b0;
    #24 scl_drv_out = 1'b0;
    #12;
  endtask : start
  task automatic rstart();
    sda_drv_out = 1'b1;
    #12 scl_drv_out = 1'b1;
    #24 start();
  endtask : rstart
  task automatic stop();
    sda_drv_out = 1'b0;
    #12 scl_drv_out = 1'b1;
    #24 sda_drv_out = 1'b1;
    #24;
  endtask : stop
  task automatic clk(output logic s);
    int n;
    #12 scl_drv_out = 1'b1;
    n = 0;
    // the slave may hold the clock low
    while (scl_in !== 1'b1 && n < 5000) begin
      #4 n++;
    end
    if (n >= 5000) begin
      hung = 1'b1;
    end
    s = sda_in;
    #24 scl_drv_out = 1'b0;
    #12;
  endtask : clk
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_drv_out = b[i];
      clk(s);
    end
    sda_drv_out = 1'b1;
    clk(s);
    ack = !s;
  endtask : xfer
endmodule : ssa_master

// ===== dv/i2c_slave_address_receive_bench.sv
// self-checking bench for the two-wire slave address receiver
`timescale 1ns/100ps
module i2c_slave_address_receive_bench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic ten_bit_mode_in = 1'b0;
  logic [7:0] own_addr_in = 8'h00;
  logic own_addr_wr_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic irq_clear_in = 1'b0;
  logic ovf_clear_in = 1'b0;
  logic irq_enable_in = 1'b1;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, rx_valid_out, buffer_full_out;
  logic overflow_out, irq_flag_out, irq_out, addr_update_out, read_write_out;
  logic [7:0] rx_data_out;
  logic m_scl, m_sda;
  int n_errors = 0;
  int check_count = 0;
  // open drain with pull-up: low if any party pulls
  wire logic scl_in = m_scl & ~scl_oe_out;
  wire logic sda_in = m_sda & ~sda_oe_out;
  always #12.5 mclk_in = ~mclk_in;
  ssa_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .enable_in(enable_in), .ten_bit_mode_in(ten_bit_mode_in),
    .own_addr_in(own_addr_in), .own_addr_wr_in(own_addr_wr_in),
    .rx_ready_in(rx_ready_in), .irq_clear_in(irq_clear_in),
    .ovf_clear_in(ovf_clear_in), .irq_enable_in(irq_enable_in),
    .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
    .buffer_full_out(buffer_full_out), .overflow_out(overflow_out),
    .irq_flag_out(irq_flag_out), .irq_out(irq_out),
    .addr_update_out(addr_update_out), .read_write_out(read_write_out));
  ssa_master u_m (.scl_drv_out(m_scl), .sda_drv_out(m_sda), .scl_in(scl_in), .sda_in(sda_in));
  // =============================================================
  // tasks
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_flag
  // strobes: own address write, buffer read, irq clear, overflow clear
  task automatic sw(input logic [3:0] m);
    @(negedge mclk_in);
    {own_addr_wr_in, rx_ready_in, irq_clear_in, ovf_clear_in} = m;
    @(negedge mclk_in);
    {own_addr_wr_in, rx_ready_in, irq_clear_in, ovf_clear_in} = 4'h0;
    @(negedge mclk_in);
  endtask : sw
  task automatic rd(input logic [7:0] exp);
    chk_byte(rx_data_out, exp);
    sw(4'h4);
    chk_flag(buffer_full_out, 1'b0);
  endtask : rd
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_m.xfer(b, a);
    // a clock held low past the model's bound counts as a failure
    if (u_m.hung) begin
      n_errors++;
    end
    chk_flag(a, exp_ack);
    // flags land a few core cycles after the ninth fall
    repeat (8) @(negedge mclk_in);
  endtask : send
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
  // =============================================================
  // scenarios
  initial begin
    repeat (8) @(negedge mclk_in);
    rst_n_in = 1'b1;
    enable_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    own_addr_in = 8'ha4;
    sw(4'h8);
    u_m.start();
    send(8'ha4, 1'b1);
    chk_flag(scl_out | sda_out, 1'b0);
    chk_flag(irq_flag_out, 1'b1);
    chk_flag(irq_out, 1'b1);
    chk_flag(read_write_out, 1'b0);
    rd(8'ha4);
    sw(4'h2);
    chk_flag(irq_flag_out, 1'b0);
    send(8'h5a, 1'b1);
    chk_flag(irq_flag_out, 1'b1);
    sw(4'h2);
    irq_enable_in = 1'b0;
    send(8'h3c, 1'b0);
    chk_flag(overflow_out, 1'b1);
    chk_flag(irq_flag_out, 1'b1);
    chk_flag(irq_out, 1'b0);
    rd(8'h5a);
    send(8'h77, 1'b0);
    chk_flag(buffer_full_out, 1'b0);
    sw(4'h3);
    chk_flag(overflow_out, 1'b0);
    u_m.stop();
    $display("test seven bit done");
    u_m.start();
    send(8'h50, 1'b0);
    send(8'ha4, 1'b0);
    chk_flag(irq_flag_out, 1'b0);
    u_m.stop();
    $display("test mismatch done");
    ten_bit_mode_in = 1'b1;
    own_addr_in = 8'hf2;
    sw(4'h8);
    u_m.start();
    send(8'hf2, 1'b1);
    chk_flag(addr_update_out, 1'b1);
    chk_flag(scl_oe_out, 1'b1);
    rd(8'hf2);
    sw(4'h2);
    own_addr_in = 8'h34;
    sw(4'h8);
    chk_flag(addr_update_out, 1'b0);
    chk_flag(scl_oe_out, 1'b0);
    send(8'h34, 1'b1);
    chk_flag(addr_update_out, 1'b1);
    rd(8'h34);
    sw(4'h2);
    own_addr_in = 8'hf2;
    sw(4'h8);
    u_m.rstart();
    send(8'hf3, 1'b1);
    chk_flag(irq_flag_out, 1'b1);
    chk_flag(read_write_out, 1'b1);
    chk_flag(addr_update_out, 1'b0);
    rd(8'hf3);
    sw(4'h2);
    u_m.rstart();
    send(8'hf0, 1'b0);
    u_m.rstart();
    send(8'hf3, 1'b0);
    chk_flag(irq_flag_out, 1'b0);
    u_m.stop();
    $display("test ten bit done");
    end_of_test();
  end
endmodule : i2c_slave_address_receive_bench
bind ssa_top ssa_asserts u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .ten_bit_mode_in(ten_bit_mode_in), .own_addr_wr_in(own_addr_wr_in),
  .irq_clear_in(irq_clear_in), .ovf_clear_in(ovf_clear_in),
  .irq_enable_in(irq_enable_in), .sda_oe_out(sda_oe_out), .scl_oe_out(scl_oe_out),
  .rx_valid_out(rx_valid_out), .buffer_full_out(buffer_full_out),
  .overflow_out(overflow_out), .irq_flag_out(irq_flag_out), .irq_out(irq_out),
  .addr_update_out(addr_update_out));
